// ==== rtl/sram_pkg.sv ====
/*
 * Shared constants of the flow-through burst static memory: array shape,
 * byte lanes, burst counter width and the access state encoding.
 * Assumes nothing of its surroundings; pulled in by scoped names only.
 */
package sram_pkg;

    // ------------------------------------------------------------------
    // Array shape
    // ------------------------------------------------------------------
    localparam int ADDR_W = 17;            // Word address bits
    localparam int DEPTH = 131072;         // Words stored
    localparam int DATA_W = 36;            // Word width, 32 on the narrow variant
    localparam int LANES = 4;              // Byte lanes per word
    localparam int BURST_W = 2;            // Burst counter bits, four-word wrap

    // ------------------------------------------------------------------
    // Reset values and the all-lanes write mask
    // ------------------------------------------------------------------
    localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
    localparam logic [LANES-1:0] MASK_NONE = 4'h0;
    localparam logic [LANES-1:0] MASK_ALL = 4'hf;

    // ------------------------------------------------------------------
    // Access state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } acc_state_t;

endpackage

// ==== rtl/flow_through_burst_sram.sv ====
/*
 * Synchronous side of a flow-through burst static memory: two address
 * strobes, three chip selects, a four-word burst counter with interleaved
 * or linear order, global and per-lane writes, and the shared data pins
 * split into input, output and output enable.
 * Assumes every input is synchronous to core_clk, including the output
 * enable, the sleep request and the burst order select; the bench resolves
 * the data wire from dq_out and dq_oe.
 */
`timescale 1ns/10ps

module flow_through_burst_sram #(
    parameter int ADDR_W = sram_pkg::ADDR_W,
    parameter int DEPTH = sram_pkg::DEPTH,
    parameter int DATA_W = sram_pkg::DATA_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Address and strobes
    input wire logic [ADDR_W-1:0] addr,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    // Chip selects
    input wire logic master_select_n,
    input wire logic select_high,
    input wire logic select_low_n,
    // Write enables
    input wire logic all_bytes_write_n,
    input wire logic byte_write_qualifier_n,
    input wire logic [sram_pkg::LANES-1:0] lane_write_n_vector,
    // Static and power controls
    input wire logic out_en_n,
    input wire logic burst_order_sel_n,
    input wire logic sleep_request,
    // Data pins
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe
);

    // ------------------------------------------------------------------
    // Local shape
    // ------------------------------------------------------------------
    localparam int LANES = sram_pkg::LANES;
    localparam int LANE_W = DATA_W / LANES;
    localparam int BURST_W = sram_pkg::BURST_W;
    localparam int HI_W = ADDR_W - BURST_W;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sram_pkg::acc_state_t state_r;
    sram_pkg::acc_state_t state_nxt;
    logic [BURST_W-1:0] cnt_r;
    logic [BURST_W-1:0] cnt_nxt;
    logic [BURST_W-1:0] base_r;
    logic [BURST_W-1:0] base_nxt;
    logic [HI_W-1:0] hi_r;
    logic [HI_W-1:0] hi_nxt;
    logic [BURST_W-1:0] low_nxt;
    logic [ADDR_W-1:0] addr_nxt;
    logic [LANES-1:0] lane_req;
    logic [LANES-1:0] wr_mask_nxt;
    logic [LANES-1:0] wr_mask_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [DATA_W-1:0] din_r;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] dq_out_r;
    logic dq_oe_r;
    logic sel_all;
    logic proc_go;
    logic ctrl_go;
    logic strobes_idle;
    logic wr_any;
    logic drive_nxt;

    // ------------------------------------------------------------------
    // Start decode
    // ------------------------------------------------------------------
    // All three selects sampled active
    assign sel_all = ~master_select_n & select_high & ~select_low_n;

    // Processor strobe only counts while the master select is active
    assign proc_go = ~proc_addr_strobe_n & ~master_select_n;

    // Controller strobe only counts with the processor strobe high
    assign ctrl_go = ~ctrl_addr_strobe_n & proc_addr_strobe_n;

    // Both strobes high lets a running burst continue
    assign strobes_idle = proc_addr_strobe_n & ctrl_addr_strobe_n;

    // ------------------------------------------------------------------
    // Write enable decode
    // ------------------------------------------------------------------
    // Global write takes all lanes, else qualifier gates the lane pins
    always_comb begin
        if (!all_bytes_write_n) begin
            lane_req = sram_pkg::MASK_ALL;
        end else if (!byte_write_qualifier_n) begin
            lane_req = ~lane_write_n_vector;
        end else begin
            lane_req = sram_pkg::MASK_NONE;
        end
    end

    // No lane requested leaves the cycle a read
    assign wr_any = |lane_req;

    // ------------------------------------------------------------------
    // Access sequencing
    // ------------------------------------------------------------------
    // Chooses start, continuation or deselect for this edge
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        base_nxt = base_r;
        hi_nxt = hi_r;
        wr_mask_nxt = sram_pkg::MASK_NONE;
        if (sleep_request) begin
            state_nxt = sram_pkg::ST_IDLE;
        end else if (proc_go) begin
            if (sel_all) begin
                // Writes and advance are not looked at on this edge
                base_nxt = addr[BURST_W-1:0];
                hi_nxt = addr[ADDR_W-1:BURST_W];
                cnt_nxt = sram_pkg::CNT_RST;
                state_nxt = sram_pkg::ST_READ;
            end else begin
                state_nxt = sram_pkg::ST_IDLE;
            end
        end else if (ctrl_go) begin
            if (sel_all) begin
                base_nxt = addr[BURST_W-1:0];
                hi_nxt = addr[ADDR_W-1:BURST_W];
                cnt_nxt = sram_pkg::CNT_RST;
                // First access may already be a write
                wr_mask_nxt = lane_req;
                state_nxt = wr_any ? sram_pkg::ST_WRITE : sram_pkg::ST_READ;
            end else begin
                state_nxt = sram_pkg::ST_IDLE;
            end
        end else if (strobes_idle && state_r != sram_pkg::ST_IDLE) begin
            if (!burst_advance_n) begin
                // Step for reads and writes alike
                cnt_nxt = cnt_r + 2'h1;
            end
            wr_mask_nxt = lane_req;
            state_nxt = wr_any ? sram_pkg::ST_WRITE : sram_pkg::ST_READ;
        end else begin
            state_nxt = state_r;
        end
    end

    // ------------------------------------------------------------------
    // Burst address
    // ------------------------------------------------------------------
    // Interleaved order flips start bits, linear order adds with wrap
    always_comb begin
        if (burst_order_sel_n) begin
            low_nxt = base_nxt ^ cnt_nxt;
        end else begin
            low_nxt = base_nxt + cnt_nxt;
        end
    end

    assign addr_nxt = {hi_nxt, low_nxt};

    // Output drive for the access taken on this edge
    assign drive_nxt = (state_nxt == sram_pkg::ST_READ) & ~out_en_n;

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    // Access state and burst position
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_r <= sram_pkg::ST_IDLE;
            cnt_r <= sram_pkg::CNT_RST;
            base_r <= sram_pkg::CNT_RST;
            hi_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            base_r <= base_nxt;
            hi_r <= hi_nxt;
        end
    end

    // Data input register and the pending write it feeds
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_mask_r <= sram_pkg::MASK_NONE;
            wr_addr_r <= '0;
            din_r <= '0;
        end else begin
            wr_mask_r <= wr_mask_nxt;
            if (wr_mask_nxt != sram_pkg::MASK_NONE) begin
                din_r <= dq_in;
                wr_addr_r <= addr_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Storage lanes
    // ------------------------------------------------------------------
    // Each lane owns its array; a pending write lands one edge late,
    // so a read of that word takes the captured data instead
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            logic [LANE_W-1:0] lane_mem [DEPTH];

            // Commit the captured lane
            always_ff @(posedge core_clk) begin
                if (wr_mask_r[gi]) begin
                    lane_mem[wr_addr_r] <= din_r[gi*LANE_W +: LANE_W];
                end
            end

            // Bypass a lane still waiting to be committed
            assign rd_word[gi*LANE_W +: LANE_W] =
                (wr_mask_r[gi] && wr_addr_r == addr_nxt) ?
                din_r[gi*LANE_W +: LANE_W] : lane_mem[addr_nxt];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    // Word of the address taken on this edge reaches the pins now
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dq_out_r <= '0;
        end else if (state_nxt == sram_pkg::ST_READ) begin
            dq_out_r <= rd_word;
        end
    end

    // Drivers on only for a selected read with output enable low
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dq_oe_r <= 1'b0;
        end else begin
            dq_oe_r <= drive_nxt;
        end
    end

    assign dq_out = dq_out_r;
    assign dq_oe = dq_oe_r;

endmodule

// ==== testbench/sram_burst_properties.sv ====
/*
 * Port checker for the flow-through burst memory.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module sram_burst_properties #(
    parameter int ADDR_W = 17,
    parameter int DATA_W = 36
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Address, strobes and selects
    input wire logic [ADDR_W-1:0] addr,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic master_select_n,
    input wire logic select_high,
    input wire logic select_low_n,
    // Writes and controls
    input wire logic all_bytes_write_n,
    input wire logic byte_write_qualifier_n,
    input wire logic [sram_pkg::LANES-1:0] lane_write_n_vector,
    input wire logic out_en_n,
    input wire logic burst_order_sel_n,
    input wire logic sleep_request,
    // Data pins
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Decoded select, write command and drive enable terms
    wire sel3 = !master_select_n && select_high && !select_low_n;
    wire wr_cmd = !all_bytes_write_n
        || (!byte_write_qualifier_n && lane_write_n_vector != 4'hf);
    wire go = !out_en_n && !sleep_request;

    // ----
    // Pin drive
    // ----
    rst_clear_a: assert property (disable iff (1'b0) !nrst |=> !dq_oe && dq_out == '0)
        else $error("reset left pins driven");
    sleep_float_a: assert property (sleep_request |=> !dq_oe)
        else $error("sleep left pins driven");
    oe_off_a: assert property (out_en_n |=> !dq_oe)
        else $error("pins driven with enable off");
    write_off_a: assert property (proc_addr_strobe_n && wr_cmd |=> !dq_oe)
        else $error("pins driven in write");
    proc_read_a: assert property (!proc_addr_strobe_n && sel3 && go |=> dq_oe)
        else $error("processor start gave no read");
    proc_desel_a: assert property (!proc_addr_strobe_n && !master_select_n && !sel3 |=> !dq_oe)
        else $error("partial select not deselected");
    ctrl_block_a: assert property (!ctrl_addr_strobe_n && proc_addr_strobe_n && master_select_n
        |=> !dq_oe)
        else $error("controller start without master select");
    read_hold_a: assert property (dq_oe && proc_addr_strobe_n && ctrl_addr_strobe_n && !wr_cmd
        && go |=> dq_oe)
        else $error("read continuation dropped");
    proc_block_a: assert property (dq_oe && !proc_addr_strobe_n && master_select_n && go
        && ctrl_addr_strobe_n && all_bytes_write_n |=> dq_oe && $stable(dq_out))
        else $error("blocked start changed the read");
endmodule

bind flow_through_burst_sram sram_burst_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
    .core_clk(core_clk), .nrst(nrst), .addr(addr), .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .master_select_n(master_select_n), .select_high(select_high), .select_low_n(select_low_n),
    .all_bytes_write_n(all_bytes_write_n), .byte_write_qualifier_n(byte_write_qualifier_n),
    .lane_write_n_vector(lane_write_n_vector), .out_en_n(out_en_n),
    .burst_order_sel_n(burst_order_sel_n), .sleep_request(sleep_request), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));

// ==== testbench/bus_host_model.sv ====
/*
 * Host side of the data pins: host driver and resolved wire.
 * Assumes dq_oe is high while the memory drives.
 */
`timescale 1ns/10ps
module bus_host_model (
    // Clock
    input wire logic core_clk,
    // Memory side
    input wire logic [35:0] dq_out,
    input wire logic dq_oe,
    // Host side
    input wire logic host_oe,
    input wire logic [35:0] host_data,
    output logic [35:0] dq_in
);
    logic [35:0] last_r = 36'h0;

    // Resolve the wire; an idle wire shows a changing pattern
    always_comb begin
        if (dq_oe && host_oe)
            dq_in = 36'hx;
        else if (dq_oe)
            dq_in = dq_out;
        else if (host_oe)
            dq_in = host_data;
        else
            dq_in = ~last_r;
    end

    // Remember the last wire value
    always_ff @(posedge core_clk)
        last_r <= dq_in;
endmodule

// ==== testbench/flow_through_burst_sram_tb.sv ====
/*
 * Bench: reset, burst writes and reads, lane writes, selects, sleep.
 * Assumes the host model resolves the data wire.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module flow_through_burst_sram_tb;
    localparam logic [16:0] BASE = 17'h1fffd;
    logic core_clk = 1'b0, nrst = 1'b0, p_n = 1'b1, c_n = 1'b1, v_n = 1'b1, g_n = 1'b1;
    logic q_n = 1'b1, m_n = 1'b0, s_hi = 1'b1, oe_n = 1'b0, ord_n = 1'b1, zz = 1'b0, h_oe = 1'b0;
    logic s_lo_n = 1'b0;
    logic [3:0] l_n = 4'hf;
    logic [16:0] a = 17'h0;
    logic [35:0] h_d = 36'h0, w, dq_out, dq_in;
    logic [35:0] ref_w [int];
    logic dq_oe;
    int n_errors = 0, comparisons = 0, cycles = 0;

    flow_through_burst_sram dut_u (.core_clk(core_clk), .nrst(nrst), .addr(a),
        .proc_addr_strobe_n(p_n), .ctrl_addr_strobe_n(c_n), .burst_advance_n(v_n),
        .master_select_n(m_n), .select_high(s_hi), .select_low_n(s_lo_n),
        .all_bytes_write_n(g_n), .byte_write_qualifier_n(q_n), .lane_write_n_vector(l_n),
        .out_en_n(oe_n), .burst_order_sel_n(ord_n), .sleep_request(zz), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));
    bus_host_model host_u (.core_clk(core_clk), .dq_out(dq_out), .dq_oe(dq_oe),
        .host_oe(h_oe), .host_data(h_d), .dq_in(dq_in));

    always #50 core_clk = ~core_clk;

    // Verdict
    task automatic finish_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 400) begin
            n_errors++;
            finish_test();
        end
    end

    // One bus cycle; the host drives the pins only for its own writes
    task automatic op(input logic p, c, v, g, q, input logic [3:0] l, input logic [16:0] ad,
                      input logic [35:0] d);
        {p_n, c_n, v_n, g_n, q_n, l_n, a, h_d} = {p, c, v, g, q, l, ad, d};
        h_oe = p & (!g | (!q & l != 4'hf));
        oe_n = h_oe;
        @(posedge core_clk);
        #1;
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        `CHK("rst_oe", 1'b0, dq_oe)
        op(1, 1, 1, 1, 1, 4'hf, 17'h0, 36'h0);
        // Controller strobe burst write, interleaved, top of the array
        for (int i = 0; i < 4; i++) begin
            w = 36'h9a5c30f00 + i;
            op(1, i != 0, i == 0, 0, 1, 4'hf, BASE, w);
            ref_w[BASE ^ i] = w;
            `CHK("wr_oe", 1'b0, dq_oe)
        end
        // Processor strobe burst read, linear order
        ord_n = 1'b0;
        for (int i = 0; i < 4; i++) begin
            op(i != 0, 1, i == 0, 1, 1, 4'hf, BASE, 36'h0);
            `CHK("lin_rd", ref_w[(BASE - 1) + ((1 + i) % 4)], dq_out)
            `CHK("rd_oe", 1'b1, dq_oe)
        end
        // Lanes and advance ignored on the processor edge, then lanes 1 and 2
        ord_n = 1'b1;
        op(0, 1, 0, 1, 0, 4'h0, BASE, 36'h0);
        `CHK("p_lane", ref_w[BASE], dq_out)
        // Host lets the memory release the pins before it drives them
        oe_n = 1'b1;
        @(posedge core_clk);
        #1;
        `CHK("ta_oe", 1'b0, dq_oe)
        op(1, 1, 1, 1, 0, 4'h9, BASE, 36'hfffffffff);
        ref_w[BASE] = ref_w[BASE] | 36'h007fffe00;
        `CHK("ln_oe", 1'b0, dq_oe)
        op(1, 1, 1, 1, 1, 4'h0, BASE, 36'h0);
        `CHK("ln_rd", ref_w[BASE], dq_out)
        // Master select blocks the processor strobe, then deselects on the controller one
        m_n = 1'b1;
        op(0, 1, 1, 1, 1, 4'hf, BASE + 2, 36'h0);
        `CHK("blk_rd", ref_w[BASE], dq_out)
        op(1, 0, 1, 1, 1, 4'hf, BASE + 2, 36'h0);
        `CHK("blk_oe", 1'b0, dq_oe)
        m_n = 1'b0;
        s_hi = 1'b0;
        op(0, 1, 1, 1, 1, 4'hf, BASE, 36'h0);
        `CHK("sel_oe", 1'b0, dq_oe)
        s_hi = 1'b1;
        s_lo_n = 1'b1;
        op(0, 1, 1, 1, 1, 4'hf, BASE, 36'h0);
        `CHK("sel_lo_oe", 1'b0, dq_oe)
        s_lo_n = 1'b0;
        // Both strobes low with global write: a read, nothing stored
        op(0, 0, 1, 0, 1, 4'hf, BASE - 1, 36'h123456789);
        `CHK("pc_oe", 1'b1, dq_oe)
        op(1, 1, 1, 1, 1, 4'hf, BASE, 36'h0);
        `CHK("pc_rd", ref_w[BASE - 1], dq_out)
        // Sleep floats the pins and keeps the array
        zz = 1'b1;
        op(1, 1, 1, 1, 1, 4'hf, BASE, 36'h0);
        `CHK("zz_oe", 1'b0, dq_oe)
        zz = 1'b0;
        op(0, 1, 1, 1, 1, 4'hf, BASE + 1, 36'h0);
        `CHK("zz_rd", ref_w[BASE + 1], dq_out)
        finish_test();
    end
endmodule
